// ==== tb/flyback_props.sv ====
// Link checker: request pulse, hold-off, off-time
`timescale 1ns/1ps
module flyback_props import flyback_pkg::*; #(
  parameter int unsigned TOFF = TOFF_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic fwd_fall
);
  logic [11:0] pend_q;
  logic [11:0] off_q;
  // Ages since request and since fall; saturate so a stall never wraps
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 12'h000;
      off_q <= 12'h000;
    end else begin
      pend_q <= req ? 12'h001 : fwd_fall ? 12'h000 : pend_q + {11'h000, pend_q != 12'h000 && pend_q != 12'hfff};
      off_q <= fwd_fall ? 12'h001 : off_q + {11'h000, off_q != 12'h000 && off_q != 12'hfff};
    end
  end
  ////////////////////////////////
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence s_req;
    req;
  endsequence
  sequence s_quiet;
    !req [*4];
  endsequence
  property p_req_pulse;
    s_req |=> s_quiet;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request not a pulse");
  property p_pend_hold;
    pend_q != 12'h000 && pend_q < REQ_TO_CYC - 1 |-> !req;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("request while pending");
  property p_off_time;
    off_q != 12'h000 && off_q < TOFF - 1 |-> !req;
  endproperty
  a_off_time: assert property (p_off_time) else $error("request in off-time");
  property p_fwd_pulse;
    fwd_fall |=> !fwd_fall;
  endproperty
  a_fwd_pulse: assert property (p_fwd_pulse) else $error("fall not a pulse");
  property p_hs_start;
    $rose(rst_b) |-> ##[1:16] req;
  endproperty
  a_hs_start: assert property (p_hs_start) else $error("no handshake request");
  // Each fall is followed by at least 8 cycles without another fall, half the on-time
  sequence s_fall;
    fwd_fall;
  endsequence
  sequence s_conduct;
    !fwd_fall [*8];
  endsequence
  property p_fall_gap;
    s_fall |=> s_conduct;
  endproperty
  a_fall_gap: assert property (p_fall_gap) else $error("fall without conduction");
endmodule : flyback_props

// ==== tb/testbench.sv ====
// Bench: both link ends, AXI registers, fault, watchdog, strap
`timescale 1ns/1ps
module testbench import flyback_pkg::*;;
  localparam int unsigned WD = 5000;
  logic mclk = 1'b0, rst_b = 1'b0, demand = 1'b1, sr_zero_cross = 1'b0, current_sense_input_over3x = 1'b0;
  logic output_voltage_sense_above_3v6 = 1'b1, output_voltage_sense_in_reg = 1'b0, qr_cal_done = 1'b1, sr_pin_open = 1'b0;
  logic sr_pin_grounded = 1'b0, line_ok = 1'b1, sr_hi = 1'b0;
  logic [2:0] fault_in = 3'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic sr_gate, qr_enable, bus_switch_en, scl_o, scl_oe_b, switching, slave_mode, auto_restart;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] output_voltage_sense_target;
  logic [7:0] iset_code;
  logic [6:0] ilim_pct;
  int n_errors = 0;
  int num_checks = 0;
  ////////////////////////////////
  feedback_link_if lnk (.mclk, .rst_b);
  secondary_ctrl #(.AR_CYC(3000), .SOFT_LEN(3000), .WD_LEN(WD)) u_secondary_ctrl (.mclk, .rst_b, .lnk, .demand,
    .sr_zero_cross, .current_sense_input_over3x, .output_voltage_sense_above_3v6, .output_voltage_sense_in_reg, .qr_cal_done, .fault_in, .sr_pin_open,
    .sr_pin_grounded, .sr_gate, .qr_enable, .bus_switch_en, .output_voltage_sense_target, .iset_code, .scl_o, .scl_oe_b,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  primary_ctrl #(.AR_CYC(3000), .AR_OFF(500)) u_primary_ctrl (.mclk, .rst_b, .lnk, .line_ok, .switching,
    .slave_mode, .auto_restart, .ilim_pct);
  flyback_props #(.TOFF(TOFF_CYC)) u_props (.mclk, .rst_b, .req(lnk.req), .fwd_fall(lnk.fwd_fall));
  ////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Clamp a set point to its legal span
  function automatic logic [31:0] cl(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return v < lo ? lo : v > hi ? hi : v;
  endfunction : cl
  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  // Bounded wait for the primary to hand over control
  task automatic hs();
    for (int i = 0; i < 20000 && slave_mode !== 1'b1; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, slave_mode}, 32'h1);
    chk({25'h0, ilim_pct}, 32'd100);
  endtask : hs
  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////
  // 40 MHz clock
  initial forever #12.5 mclk = ~mclk;
  // Random demand and surges; gate must be low whenever a request leaves
  always @(posedge mclk) begin
    demand <= ($urandom % 4) != 0;
    current_sense_input_over3x <= ($urandom % 8) == 0;
    if (!rst_b) sr_hi <= 1'b0;
    else if (sr_gate === 1'b1) sr_hi <= 1'b1;
    if (lnk.req === 1'b1) chk({31'h0, sr_gate}, 32'h0);
  end
  // Main sequence
  initial begin
    logic [11:0] v;
    logic [7:0] c;
    void'($urandom(32'hfd3b));
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    chk({25'h0, ilim_pct}, 32'd75);
    chk({20'h0, output_voltage_sense_target}, 32'd500);
    chk({24'h0, iset_code}, 32'd192);
    chk({31'h0, qr_enable}, 32'h1);
    chk({30'h0, switching, auto_restart}, 32'h0);
    chk({31'h0, scl_o}, 32'h0);
    rd(ADDR_VSET, 32'd500, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      v = i == 0 ? 12'h000 : i == 1 ? 12'hfff : 12'($urandom);
      c = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
      wr(ADDR_VSET, {20'h0, v}, RESP_OKAY);
      rd(ADDR_VSET, cl(v, 300, 3000), RESP_OKAY);
      chk({20'h0, output_voltage_sense_target}, cl(v, 300, 3000));
      wr(ADDR_ISET, {24'h0, c}, RESP_OKAY);
      rd(ADDR_ISET, cl(c, 29, 192), RESP_OKAY);
      chk({24'h0, iset_code}, cl(c, 29, 192));
    end
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(ADDR_SRPROT, 32'h0e09, RESP_OKAY);
    rd(ADDR_SRPROT, 32'h0, RESP_OKAY);
    wr(ADDR_SRPROT, 32'h0201, RESP_OKAY);
    hs();
    output_voltage_sense_in_reg <= 1'b1;
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    wr(ADDR_RESP, 32'h1, RESP_OKAY);
    fault_in <= 3'h1;
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, scl_oe_b}, 32'h0);
    repeat (2150) @(posedge mclk);
    #1;
    chk({31'h0, scl_oe_b}, 32'h0);
    repeat (100) @(posedge mclk);
    #1;
    chk({31'h0, scl_oe_b}, 32'h1);
    chk({31'h0, bus_switch_en}, 32'h1);
    rd(ADDR_FAULT, 32'h1, RESP_OKAY);
    fault_in <= 3'h0;
    wr(ADDR_FAULT, 32'h1, RESP_OKAY);
    rd(ADDR_FAULT, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    chk({31'h0, bus_switch_en}, 32'h0);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    wr(ADDR_VSET, 32'd1000, RESP_OKAY);
    repeat (WD - 1000) @(posedge mclk);
    #1;
    chk({20'h0, output_voltage_sense_target}, 32'd1000);
    repeat (1100) @(posedge mclk);
    #1;
    chk({20'h0, output_voltage_sense_target}, 32'd500);
    chk({31'h0, bus_switch_en}, 32'h0);
    chk({31'h0, sr_hi}, 32'h1);
    rst_b <= 1'b0;
    sr_pin_grounded <= 1'b1;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    hs();
    repeat (2000) @(posedge mclk);
    chk({31'h0, sr_hi}, 32'h0);
    complete_run();
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
endmodule : testbench

// ==== verilog/feedback_link_if.sv ====
// Isolated feedback link between secondary and primary controllers
`timescale 1ns/1ps
interface feedback_link_if (
  input wire logic mclk,
  input wire logic rst_b
);
  logic req;
  logic fwd_fall;
  modport sec (input mclk, input rst_b, output req, input fwd_fall);
  modport pri (input mclk, input rst_b, input req, output fwd_fall);
endinterface : feedback_link_if

// ==== verilog/flyback_pkg.sv ====
// Shared constants and types for the flyback request link and its two ends
package flyback_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  // Times as printed, then cycle counts
  localparam int unsigned T_AR_MS = 82;
  localparam int unsigned T_AR_CYC = T_AR_MS * (CLK_HZ / 1000);
  localparam int unsigned T_SOFT_MS = 10;
  localparam int unsigned SOFT_CYC = T_SOFT_MS * (CLK_HZ / 1000);
  localparam int unsigned T_REQ_TO_US = 30;
  localparam int unsigned REQ_TO_CYC = T_REQ_TO_US * CLK_MHZ;
  localparam int unsigned T_HS_GAP_US = 30;
  localparam int unsigned HS_CYC = T_HS_GAP_US * CLK_MHZ;
  localparam int unsigned HS_MIN_CYC = HS_CYC / 2;
  localparam int unsigned HS_MAX_CYC = HS_CYC + HS_CYC / 2;
  localparam int unsigned T_IRQ_US = 55;
  localparam int unsigned IRQ_CYC = T_IRQ_US * CLK_MHZ;
  localparam int unsigned F_START_HZ = 100_000;
  localparam int unsigned START_PER_CYC = CLK_HZ / F_START_HZ;
  localparam int unsigned F_MAX_HZ = 125_000;
  localparam int unsigned TOFF_CYC = 40;
  localparam int unsigned ON_CYC = 16;
  localparam int unsigned AR_OFF_CYC = 40_000_000;
  localparam int unsigned WD_CYC = 40_000_000;
  localparam logic [6:0] ILIM_START_PCT = 7'h4b;
  localparam logic [6:0] ILIM_FULL_PCT = 7'h64;
  localparam int unsigned MISS_MAX = 8;
  localparam int unsigned UNREQ_MAX = 4;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RESP = 8'h04;
  localparam logic [7:0] ADDR_VSET = 8'h08;
  localparam logic [7:0] ADDR_ISET = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_FAULT = 8'h14;
  localparam logic [7:0] ADDR_SRPROT = 8'h38;
  // Set points: 10 mV and 0.52 % per code
  localparam logic [11:0] VSET_MIN = 12'h12c;
  localparam logic [11:0] VSET_MAX = 12'hbb8;
  localparam logic [11:0] VSET_DEF = 12'h1f4;
  localparam logic [7:0] ISET_MIN = 8'h1d;
  localparam logic [7:0] ISET_MAX = 8'hc0;
  localparam logic [15:0] SRPROT_RST = 16'h0201;
  localparam int unsigned SRP_EN_BIT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FR_NONE = 2'h0, FR_AR = 2'h1, FR_LO = 2'h2, FR_DIS = 2'h3
  } fault_resp_t;
  typedef enum logic [5:0] {
    S_HS = 6'h01, S_SOFT = 6'h02, S_RUN = 6'h04, S_AR = 6'h08, S_LATCH = 6'h10, S_DIS = 6'h20
  } sec_state_t;
  typedef enum logic [3:0] {
    P_WAIT = 4'h1, P_SELF = 4'h2, P_SLAVE = 4'h4, P_AR = 4'h8
  } pri_state_t;
endpackage : flyback_pkg

// ==== verilog/primary_ctrl.sv ====
// Primary-side switching controller end of the feedback link
`timescale 1ns/1ps
module primary_ctrl import flyback_pkg::*; #(
  parameter int unsigned AR_CYC = T_AR_CYC,
  parameter int unsigned AR_OFF = AR_OFF_CYC,
  parameter int unsigned ON_LEN = ON_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  feedback_link_if.pri lnk,
  input wire logic line_ok,
  output logic switching,
  output logic slave_mode,
  output logic auto_restart,
  output logic [6:0] ilim_pct
);
  typedef struct packed {
    pri_state_t st;
    logic [25:0] tmr;
    logic [10:0] gap;
    logic seen1;
    logic [9:0] per;
    logic [5:0] on_t;
    logic on;
    logic fall;
    logic [6:0] ilim;
  } pri_t;

  pri_t q;
  pri_t d;
  logic pair;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d = q;
    d.fall = 1'b0;
    // two requests about 30 us apart
    pair = lnk.req && q.seen1 && q.gap >= 11'(HS_MIN_CYC) && q.gap <= 11'(HS_MAX_CYC);
    d.gap = (q.gap == 11'h7ff) ? q.gap : q.gap + 11'h1;
    if (lnk.req) begin
      d.seen1 = 1'b1;
      d.gap = 11'h0;
    end
    // Conduction ends with a forward fall pulse
    if (q.on) begin
      if (q.on_t == 6'h0) begin
        d.on = 1'b0;
        d.fall = 1'b1;
      end else begin
        d.on_t = q.on_t - 6'h1;
      end
    end
    case (q.st)
      P_WAIT: begin
        d.tmr = q.tmr + 26'h1;
        if (pair) begin
          d.st = P_SLAVE;
          d.tmr = 26'h0;
        end else if (q.tmr == 26'(AR_CYC - 1)) begin
          // nobody spoke, switch on own control
          d.st = P_SELF;
          d.tmr = 26'h0;
          d.per = 10'h0;
        end
      end
      P_SELF: begin
        d.ilim = ILIM_START_PCT;
        d.per = (q.per == 10'(START_PER_CYC - 1)) ? 10'h0 : q.per + 10'h1;
        if (q.per == 10'h0 && !q.on) begin
          d.on = 1'b1;
          d.on_t = 6'(ON_LEN - 1);
        end
        d.tmr = lnk.req ? 26'h0 : q.tmr + 26'h1;
        if (pair) begin
          d.st = P_SLAVE;
          d.tmr = 26'h0;
        end else if (q.tmr == 26'(AR_CYC - 1)) begin
          d.st = P_AR;
          d.tmr = 26'h0;
        end
      end
      P_SLAVE: begin
        d.ilim = ILIM_FULL_PCT;
        d.tmr = lnk.req ? 26'h0 : q.tmr + 26'h1;
        if (lnk.req && !q.on) begin
          d.on = 1'b1;
          d.on_t = 6'(ON_LEN - 1);
        end
        if (q.tmr == 26'(AR_CYC - 1)) begin
          d.st = P_AR;
          d.tmr = 26'h0;
        end
      end
      P_AR: begin
        d.tmr = q.tmr + 26'h1;
        d.on = 1'b0;
        if (q.tmr == 26'(AR_OFF - 1)) begin
          d.st = P_WAIT;
          d.tmr = 26'h0;
          d.seen1 = 1'b0;
          d.ilim = ILIM_START_PCT;
        end
      end
      default: d.st = P_AR;
    endcase
    // Line fault stops switching and restarts through the wait
    if (!line_ok) begin
      d.st = P_AR;
      d.tmr = 26'h0;
      d.on = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= P_WAIT;
      q.ilim <= ILIM_START_PCT;
    end else begin
      q <= d;
    end
  end

  assign lnk.fwd_fall = q.fall;
  assign switching = q.on;
  assign slave_mode = (q.st == P_SLAVE);
  assign auto_restart = (q.st == P_AR);
  assign ilim_pct = q.ilim;
endmodule : primary_ctrl

// ==== verilog/secondary_ctrl.sv ====
// Secondary-side cycle request controller with AXI4-Lite register slave
// How it works
// - Primary auto-restarts after 82 ms without feedback
// - Rehandshake after 8 misses or 4 unrequested
// - Primary waits, two 30us requests grant slave
// - Primary self-switches until handshake pulses arrive
// - Rectifier off before next CCM request
// - Voltage target defaults to 5 V
// - Voltage set point 3-30 V, 10 mV
// - Current set point 15-100 %, 0.52 %
// - Minimum off-time before next request
// - Four fault responses, bus switch untouched
// - Host opens bus switch itself
// - Fault pulls SCL low 55 us
// - Watchdog restores 5 V, opens switch
// - Start at 100 kHz, ramp 10 ms
// - Auto-restart if output under 3.6 V
// - Regulation aborts ramp after QR programming
// - Requests held until forward fall, 30us
// - Rectifier only on requested edge, no surge
// - Host writes protection config at 0x38
// - Protection trip also suspends QR, self-restores
// - Open rectifier drive stops all requests
// - Grounded drive at start disables drive, detection
`timescale 1ns/1ps
module secondary_ctrl import flyback_pkg::*; #(
  parameter int unsigned AR_CYC = T_AR_CYC,
  parameter int unsigned SOFT_LEN = SOFT_CYC,
  parameter int unsigned WD_LEN = WD_CYC,
  parameter int unsigned FMAX_HZ = F_MAX_HZ,
  parameter int unsigned TOFF = TOFF_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  feedback_link_if.sec lnk,
  input wire logic demand,
  input wire logic sr_zero_cross,
  input wire logic current_sense_input_over3x,
  input wire logic output_voltage_sense_above_3v6,
  input wire logic output_voltage_sense_in_reg,
  input wire logic qr_cal_done,
  input wire logic [2:0] fault_in,
  input wire logic sr_pin_open,
  input wire logic sr_pin_grounded,
  output logic sr_gate,
  output logic qr_enable,
  output logic bus_switch_en,
  output logic [11:0] output_voltage_sense_target,
  output logic [7:0] iset_code,
  output logic scl_o,
  output logic scl_oe_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    sec_state_t st;
    logic [25:0] tmr;
    logic [16:0] freq;
    logic [15:0] rdiv;
    logic [25:0] acc;
    logic credit;
    logic pend;
    logic [10:0] pend_t;
    logic [10:0] off_t;
    logic [3:0] miss;
    logic [2:0] unreq;
    logic [1:0] hs_cnt;
    logic req;
    logic sr;
    logic [2:0] srp_cnt;
    logic srp_trip;
    logic strap_done;
    logic sr_gnd;
    logic [11:0] irq_t;
    logic scl_oe_b;
    logic [2:0] flt_prev;
    logic [2:0] flt_sticky;
    logic [31:0] wd;
    logic bus_sw;
    logic [5:0] resp;
    logic [11:0] vset;
    logic [7:0] iset;
    logic [15:0] srp;
    logic awready;
    logic [7:0] awaddr;
    logic wready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sec_t;

  // Clocks per 1 Hz ramp step so the frequency rises linearly over the soft-start
  localparam int unsigned RAMP_DIV = SOFT_LEN / (FMAX_HZ - F_START_HZ + 1) + 1;

  sec_t q;
  sec_t d;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [31:0] wv;
  logic [26:0] acc_n;
  logic sr_ok;
  logic open_f;
  logic dis_f;
  logic [2:0] new_f;
  logic [2:0] thr;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d = q;
    d.req = 1'b0;
    wv = '0;
    dis_f = 1'b0;
    thr = 3'h0;
    // Strap caught in the first clock after reset release
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.sr_gnd = sr_pin_grounded;
    end
    sr_ok = q.strap_done & ~q.sr_gnd;
    open_f = sr_ok & sr_pin_open;

    // Register writes once address and data are both held
    if (s_axi_awvalid && q.awready) begin
      d.awready = 1'b0;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wready = 1'b0;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (!q.awready && !q.wready && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.awaddr)
        ADDR_CTRL: begin
          wv = merge({31'h0, q.bus_sw}, q.wdata, q.wstrb);
          d.bus_sw = wv[0];
        end
        ADDR_RESP: begin
          wv = merge({26'h0, q.resp}, q.wdata, q.wstrb);
          d.resp = wv[5:0];
        end
        ADDR_VSET: begin
          wv = merge({20'h0, q.vset}, q.wdata, q.wstrb);
          d.vset = (wv[11:0] < VSET_MIN) ? VSET_MIN : (wv[11:0] > VSET_MAX || |wv[31:12]) ? VSET_MAX : wv[11:0];
        end
        ADDR_ISET: begin
          wv = merge({24'h0, q.iset}, q.wdata, q.wstrb);
          d.iset = (wv[7:0] < ISET_MIN) ? ISET_MIN : (wv[7:0] > ISET_MAX || |wv[31:8]) ? ISET_MAX : wv[7:0];
        end
        ADDR_FAULT: begin
          wv = merge(32'h0, q.wdata, q.wstrb);
        end
        ADDR_SRPROT: begin
          wv = merge({16'h0, q.srp}, q.wdata, q.wstrb);
          d.srp = wv[15:0];
        end
        ADDR_STAT: begin
          d.bresp = RESP_OKAY;
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    // Reads answer one cycle after acceptance
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: d.rdata = {31'h0, q.bus_sw};
        ADDR_RESP: d.rdata = {26'h0, q.resp};
        ADDR_VSET: d.rdata = {20'h0, q.vset};
        ADDR_ISET: d.rdata = {24'h0, q.iset};
        ADDR_STAT: d.rdata = {22'h0, open_f, q.sr_gnd, q.srp_trip, q.sr, q.st};
        ADDR_FAULT: d.rdata = {29'h0, q.flt_sticky};
        ADDR_SRPROT: d.rdata = 32'h0;
        default: begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // write or read address acceptance feeds the watchdog
    if ((s_axi_awvalid && q.awready) || (s_axi_arvalid && q.arready)) begin
      d.wd = 32'h0;
    end else if (q.wd == 32'(WD_LEN - 1)) begin
      d.wd = 32'h0;
      d.vset = VSET_DEF;
      d.bus_sw = 1'b0;
    end else begin
      d.wd = q.wd + 32'h1;
    end

    // Sticky faults: a new fault beats a same-cycle clear
    new_f = fault_in & ~q.flt_prev;
    d.flt_prev = fault_in;
    d.flt_sticky = (q.flt_sticky & ~wv[2:0]) | new_f;
    if (q.bvalid || q.awaddr != ADDR_FAULT) begin
      d.flt_sticky = q.flt_sticky | new_f;
    end
    if (|new_f) begin
      d.irq_t = 12'(IRQ_CYC);
    end else if (q.irq_t != 12'h0) begin
      d.irq_t = q.irq_t - 12'h1;
    end
    d.scl_oe_b = (d.irq_t == 12'h0);

    // inhibit until forward fall or timeout
    if (lnk.fwd_fall && q.pend) begin
      d.pend = 1'b0;
      d.miss = 4'h0;
      d.unreq = 3'h0;
      d.srp_cnt = 3'h0;
      d.srp_trip = 1'b0;
      // off-time starts at end of conduction
      d.off_t = 11'(TOFF);
      d.hs_cnt = (q.hs_cnt == 2'h3) ? q.hs_cnt : q.hs_cnt + 2'h1;
      // drive only on a requested edge
      if (sr_ok && !current_sense_input_over3x && !q.srp_trip) begin
        d.sr = 1'b1;
      end
    end else if (lnk.fwd_fall) begin
      d.unreq = (q.unreq == 3'h7) ? q.unreq : q.unreq + 3'h1;
      d.sr = 1'b0;
      // trip past the tolerated unrequested count
      thr = q.srp[2:0];
      if (q.srp[SRP_EN_BIT]) begin
        d.srp_cnt = (q.srp_cnt == 3'h7) ? q.srp_cnt : q.srp_cnt + 3'h1;
        if (q.srp_cnt >= thr) begin
          d.srp_trip = 1'b1;
        end
      end
    end else if (q.pend) begin
      if (q.pend_t == 11'h0) begin
        d.pend = 1'b0;
        d.miss = (q.miss == 4'hf) ? q.miss : q.miss + 4'h1;
      end else begin
        d.pend_t = q.pend_t - 11'h1;
      end
    end
    // Reload at end of conduction must win over the countdown
    if (q.off_t != 11'h0 && !(lnk.fwd_fall && q.pend)) begin
      d.off_t = q.off_t - 11'h1;
    end
    // surge or zero crossing ends drive
    if (sr_zero_cross || current_sense_input_over3x || q.srp_trip || !sr_ok) begin
      d.sr = 1'b0;
    end

    // Phase accumulator gives request credits at the current frequency
    acc_n = {1'b0, q.acc} + {10'h0, q.freq};
    if (acc_n >= 27'(CLK_HZ)) begin
      d.acc = 26'(acc_n - 27'(CLK_HZ));
      d.credit = 1'b1;
    end else begin
      d.acc = acc_n[25:0];
    end

    // per-fault response, bus switch left alone
    for (int i = 0; i < 3; i++) begin
      if (fault_in[i]) begin
        case (fault_resp_t'(q.resp[2*i +: 2]))
          FR_AR: if (q.st == S_SOFT || q.st == S_RUN) begin
            d.st = S_AR;
            d.tmr = 26'h0;
          end
          FR_LO: d.st = S_LATCH;
          FR_DIS: dis_f = 1'b1;
          default: dis_f = dis_f;
        endcase
      end
    end

    case (q.st)
      S_HS: begin
        if (q.hs_cnt >= 2'h2) begin
          // ramp begins at the start frequency
          d.st = S_SOFT;
          d.tmr = 26'h0;
          d.freq = 17'(F_START_HZ);
          d.rdiv = 16'h0;
        end else if (q.tmr != 26'h0) begin
          d.tmr = q.tmr - 26'h1;
        end else if (q.sr) begin
          d.sr = 1'b0;
        end else if (!open_f && !dis_f) begin
          // Handshake pulses spaced by the listen gap
          d.req = 1'b1;
          d.pend = 1'b1;
          d.pend_t = 11'(REQ_TO_CYC);
          d.tmr = 26'(HS_CYC - 1);
        end
      end
      S_SOFT: begin
        d.tmr = q.tmr + 26'h1;
        if (q.rdiv == 16'(RAMP_DIV - 1)) begin
          d.rdiv = 16'h0;
          d.freq = (q.freq >= 17'(FMAX_HZ)) ? q.freq : q.freq + 17'h1;
        end else begin
          d.rdiv = q.rdiv + 16'h1;
        end
        if (output_voltage_sense_in_reg && qr_cal_done) begin
          d.freq = 17'(FMAX_HZ);
          d.st = S_RUN;
        end else if (q.tmr == 26'(SOFT_LEN - 1)) begin
          d.st = output_voltage_sense_above_3v6 ? S_RUN : S_AR;
          d.freq = 17'(FMAX_HZ);
          d.tmr = 26'h0;
        end
      end
      S_RUN: d.st = S_RUN;
      S_AR: begin
        // Silence lets the primary restart; hold while the drive is open
        d.tmr = open_f ? 26'h0 : q.tmr + 26'h1;
        if (q.tmr == 26'(AR_CYC - 1)) begin
          d.st = S_HS;
          d.tmr = 26'h0;
          d.hs_cnt = 2'h0;
        end
      end
      S_LATCH: d.st = S_LATCH;
      default: d.st = S_HS;
    endcase

    // lost or extra cycles force a new handshake
    if ((q.st == S_SOFT || q.st == S_RUN) && (q.miss >= 4'(MISS_MAX) || q.unreq >= 3'(UNREQ_MAX))) begin
      d.st = S_HS;
      d.tmr = 26'h0;
      d.hs_cnt = 2'h0;
      d.miss = 4'h0;
      d.unreq = 3'h0;
    end
    // open drive, no requests at all
    if (open_f) begin
      d.st = (q.st == S_LATCH) ? S_LATCH : S_AR;
    end

    // Regulation requests under inhibit, frequency and off-time limits
    if ((q.st == S_SOFT || q.st == S_RUN) && demand && q.credit && !q.pend && q.off_t == 11'h0 && !open_f && !dis_f) begin
      if (q.sr) begin
        // drop the rectifier first, request next cycle
        d.sr = 1'b0;
      end else begin
        d.req = 1'b1;
        d.pend = 1'b1;
        d.pend_t = 11'(REQ_TO_CYC);
        d.credit = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= S_HS;
      q.freq <= 17'(F_START_HZ);
      q.scl_oe_b <= 1'b1;
      q.vset <= VSET_DEF;
      q.iset <= ISET_MAX;
      q.srp <= SRPROT_RST;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign lnk.req = q.req;
  assign sr_gate = q.sr;
  assign qr_enable = ~q.srp_trip;
  assign bus_switch_en = q.bus_sw;
  assign output_voltage_sense_target = q.vset;
  assign iset_code = q.iset;
  assign scl_o = 1'b0;
  assign scl_oe_b = q.scl_oe_b;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
endmodule : secondary_ctrl
